// >>> lsc_always_on.sv
`timescale 1ns/1ps
`default_nettype none

// always-on supply enable, tracks power manager state
module lsc_always_on
	import lsc_pkg::*;
(
	// clock and reset
	input  wire logic       clock,
	input  wire logic       arst_n,
	// power manager state
	input  wire logic [2:0] pm_state,
	// supply enable
	output logic            aon_enable
);

	typedef enum logic {AON_OFF, AON_ON} lsc_aon_e;

	lsc_aon_e state_q;   // current enable state
	lsc_aon_e state_d;   // next enable state

	// switch on at entry to s4, hold through every deeper or shallower state until g3
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			AON_OFF: begin
				if (pm_state == LSC_PM_S4) begin
					state_d = AON_ON; // R8
				end
			end
			AON_ON: begin
				if (pm_state == LSC_PM_G3) begin
					state_d = AON_OFF; // R8
				end
			end
		endcase
	end

	// state register
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= AON_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	assign aon_enable = (state_q == AON_ON);

	AST_AON_ON_AT_S4: assert property (@(posedge clock) disable iff (!arst_n) // R8
		(pm_state == LSC_PM_S4) |=> aon_enable)
		else $error("always-on supply not on after s4");

	AST_AON_HOLD: assert property (@(posedge clock) disable iff (!arst_n) // R8
		(aon_enable && pm_state != LSC_PM_G3) |=> aon_enable)
		else $error("always-on supply dropped before g3");

	AST_AON_OFF_G3: assert property (@(posedge clock) disable iff (!arst_n) // R8
		(pm_state == LSC_PM_G3) |=> !aon_enable)
		else $error("always-on supply still on in g3");

endmodule

`default_nettype wire

// >>> lsc_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// host side of the register port; strobes span one full rising edge
module lsc_host_model (
	// clock
	input  wire logic       clock,
	// register port
	output logic [7:0]      reg_addr,
	output logic            reg_wr,
	output logic [7:0]      reg_wdata,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_rvalid
);
	// idle port at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end
	// one write, taken at the rising edge inside the strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clock);
		reg_wr = 1'b0;
		// stale data would hide a late capture
		reg_wdata = ~d;
	endtask
	// one read; the answer pulses in the cycle after the taking edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		@(negedge clock);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clock);
		reg_rd = 1'b0;
		ok = reg_rvalid;
		d = reg_rdata;
	endtask
endmodule

`default_nettype wire

// >>> lsc_pkg.sv
package lsc_pkg;

	// register addresses on the internal register port
	localparam logic [7:0] LSC_CTL_ADDR = 8'h6A;   // on/off control
	localparam logic [7:0] LSC_GRP_ADDR = 8'hF3;   // rail class and delay group
	localparam logic [7:0] LSC_LVL_ADDR = 8'h18;   // output level code

	// control register layout
	localparam int LSC_CTL_ON_BIT  = 0;            // supply_on_bit
	localparam int LSC_CTL_SEL_BIT = 1;            // supply_source_select
	localparam logic [7:0] LSC_CTL_RESET = 8'h00;
	localparam logic [7:0] LSC_CTL_MASK  = 8'h03;

	// sequencing register layout
	localparam int LSC_GRP_LSB   = 0;              // supply_delay_group lsb
	localparam int LSC_GRP_W     = 4;
	localparam int LSC_CLASS_LSB = 4;              // supply_rail_class lsb
	localparam int LSC_CLASS_W   = 2;
	localparam logic [7:0] LSC_GRP_MASK  = 8'h3F;
	localparam logic [3:0] LSC_GRP_MAX   = 4'hE;   // last defined group, 14
	localparam logic [7:0] LSC_GRP_RESET = 8'h00;  // held only until the otp copy lands

	// rail class encodings
	localparam logic [1:0] LSC_CLASS_A  = 2'h0;
	localparam logic [1:0] LSC_CLASS_U  = 2'h1;
	localparam logic [1:0] LSC_CLASS_S  = 2'h2;
	localparam logic [1:0] LSC_CLASS_SX = 2'h3;

	// output level register layout: code 0 is 1.00 V, +50 mV per step
	localparam int LSC_LVL_W = 6;
	localparam logic [7:0] LSC_LVL_MASK  = 8'h3F;
	localparam logic [7:0] LSC_LVL_RESET = 8'h00;
	localparam logic [5:0] LSC_LVL_MAX   = 6'h37;  // 55, 3.75 V

	// power manager state codes
	localparam logic [2:0] LSC_PM_S0 = 3'h0;
	localparam logic [2:0] LSC_PM_S3 = 3'h3;
	localparam logic [2:0] LSC_PM_S4 = 3'h4;
	localparam logic [2:0] LSC_PM_S5 = 3'h5;
	localparam logic [2:0] LSC_PM_G3 = 3'h7;

endpackage

// >>> lsc_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// [R1] select 0: sequencer request drives on/off
// [R2] select 1: control bit 0 drives on/off
// [R3] sequencer low means on, high off
// [R4] six-bit level code, 1.00 V to 3.75 V
// [R5] rail class field bits 5:4
// [R6] delay group field bits 3:0, groups 0-14
// [R7] otp defaults for sequencing, control resets zero
// [R8] always-on supply on from s4 until g3
// [R9] reserved bits read zero, writes ignored
module lsc_regs
	import lsc_pkg::*;
(
	// clock and reset
	input  wire logic       clock,
	input  wire logic       arst_n,
	// register port from the serial host engine
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_rd,
	output logic [7:0]      reg_rdata,
	output logic            reg_rvalid,
	// factory defaults
	input  wire logic [1:0] otp_rail_class,
	input  wire logic [3:0] otp_delay_group,
	// power sequencer and manager
	input  wire logic       seq_request,
	input  wire logic [2:0] pm_state,
	// supply controls
	output logic            supply_enable,
	output logic [5:0]      supply_level_code,
	output logic [1:0]      supply_rail_class,
	output logic [3:0]      supply_delay_group,
	output logic            always_on_enable
);

	logic [7:0] ctl_q, ctl_d;       // supply_onoff_control
	logic [7:0] grp_q, grp_d;       // supply_sequencing_group
	logic [7:0] lvl_q, lvl_d;       // supply_output_level
	logic       otp_done_q, otp_done_d; // defaults copied in
	logic [7:0] rdata_q, rdata_d;   // read data
	logic       rvalid_q, rvalid_d; // read answer strobe
	logic       en_q, en_d;         // supply on/off

	logic       wr_ctl, wr_grp, wr_lvl;

	assign wr_ctl = reg_wr && (reg_addr == LSC_CTL_ADDR);
	assign wr_grp = reg_wr && (reg_addr == LSC_GRP_ADDR);
	assign wr_lvl = reg_wr && (reg_addr == LSC_LVL_ADDR);

	// register writes; the otp copy happens the first cycle after reset release
	always_comb begin
		ctl_d      = ctl_q;
		grp_d      = grp_q;
		lvl_d      = lvl_q;
		otp_done_d = 1'b1;
		if (!otp_done_q) begin
			// strap-like capture, cannot be taken under the async reset itself
			grp_d = {2'h0, otp_rail_class, otp_delay_group}; // R7
		end else if (wr_grp) begin
			// class always accepted; group 15 is undefined so the old group stays
			grp_d[LSC_CLASS_LSB +: LSC_CLASS_W] = reg_wdata[LSC_CLASS_LSB +: LSC_CLASS_W]; // R5
			if (reg_wdata[LSC_GRP_LSB +: LSC_GRP_W] <= LSC_GRP_MAX) begin
				grp_d[LSC_GRP_LSB +: LSC_GRP_W] = reg_wdata[LSC_GRP_LSB +: LSC_GRP_W]; // R6
			end
		end
		if (wr_ctl) begin
			ctl_d = reg_wdata & LSC_CTL_MASK; // R9
		end
		// codes above 55 have no level, so such writes are dropped
		if (wr_lvl && (reg_wdata[LSC_LVL_W-1:0] <= LSC_LVL_MAX)) begin
			lvl_d = reg_wdata & LSC_LVL_MASK; // R4
		end
	end

	// register file
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			ctl_q      <= LSC_CTL_RESET; // R7
			grp_q      <= LSC_GRP_RESET;
			lvl_q      <= LSC_LVL_RESET;
			otp_done_q <= 1'b0;
		end else begin
			ctl_q      <= ctl_d;
			grp_q      <= grp_d;
			lvl_q      <= lvl_d;
			otp_done_q <= otp_done_d;
		end
	end

	// on/off source: sequencer is active low, unlike the sibling supply
	always_comb begin
		if (ctl_q[LSC_CTL_SEL_BIT]) begin
			en_d = ctl_q[LSC_CTL_ON_BIT]; // R2
		end else begin
			en_d = !seq_request; // R1 R3
		end
	end

	// enable flop, gives a glitch-free control to the analog side
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			en_q <= 1'b0;
		end else begin
			en_q <= en_d;
		end
	end

	// read mux, unmapped addresses answer zero
	always_comb begin
		rvalid_d = reg_rd;
		rdata_d  = rdata_q;
		if (reg_rd) begin
			unique case (reg_addr)
				LSC_CTL_ADDR: rdata_d = ctl_q & LSC_CTL_MASK; // R9
				LSC_GRP_ADDR: rdata_d = grp_q & LSC_GRP_MASK; // R9
				LSC_LVL_ADDR: rdata_d = lvl_q & LSC_LVL_MASK; // R9
				default:      rdata_d = 8'h00;
			endcase
		end
	end

	// read answer registers
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q  <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	// always-on supply tracker
	lsc_always_on u_aon ( // R8
		.clock      (clock),
		.arst_n     (arst_n),
		.pm_state   (pm_state),
		.aon_enable (always_on_enable)
	);

	assign reg_rdata          = rdata_q;
	assign reg_rvalid         = rvalid_q;
	assign supply_enable      = en_q;
	assign supply_level_code  = lvl_q[LSC_LVL_W-1:0];
	assign supply_rail_class  = grp_q[LSC_CLASS_LSB +: LSC_CLASS_W];
	assign supply_delay_group = grp_q[LSC_GRP_LSB +: LSC_GRP_W];

	AST_SEQ_SOURCE: assert property (@(posedge clock) disable iff (!arst_n) // R1
		!ctl_q[LSC_CTL_SEL_BIT] |=> (supply_enable == !$past(seq_request)))
		else $error("sequencer source not followed");

	AST_REG_SOURCE: assert property (@(posedge clock) disable iff (!arst_n) // R2
		ctl_q[LSC_CTL_SEL_BIT] |=> (supply_enable == $past(ctl_q[LSC_CTL_ON_BIT])))
		else $error("enable bit source not followed");

	AST_SEQ_LOW_ON: assert property (@(posedge clock) disable iff (!arst_n) // R3
		(!ctl_q[LSC_CTL_SEL_BIT] && !seq_request)[*2] |-> supply_enable)
		else $error("supply off with sequencer low");

	AST_LVL_RANGE: assert property (@(posedge clock) disable iff (!arst_n) // R4
		supply_level_code <= LSC_LVL_MAX)
		else $error("level code out of range");

	AST_CLASS_WRITE: assert property (@(posedge clock) disable iff (!arst_n) // R5
		(wr_grp && otp_done_q) |=> (supply_rail_class == $past(reg_wdata[5:4])))
		else $error("rail class not written");

	AST_GROUP_RANGE: assert property (@(posedge clock) disable iff (!arst_n) // R6
		otp_done_q |-> (supply_delay_group <= LSC_GRP_MAX) || $stable(supply_delay_group))
		else $error("undefined delay group accepted");

	AST_OTP_LOAD: assert property (@(posedge clock) disable iff (!arst_n) // R7
		!otp_done_q |=> (supply_rail_class == $past(otp_rail_class))
			&& (supply_delay_group == $past(otp_delay_group)))
		else $error("otp defaults not loaded");

	AST_RSVD_ZERO: assert property (@(posedge clock) disable iff (!arst_n) // R9
		reg_rvalid |-> (reg_rdata[7:6] == 2'h0))
		else $error("reserved bits read nonzero");

	AST_CTL_RSVD: assert property (@(posedge clock) disable iff (!arst_n) // R9
		(reg_rd && reg_addr == LSC_CTL_ADDR) |=> (reg_rdata[7:2] == 6'h00))
		else $error("control reserved bits nonzero");

	// a dropped level write must leave the analog code untouched
	AST_LVL_DROP: assert property (@(posedge clock) disable iff (!arst_n) // R4
		(wr_lvl && (reg_wdata[LSC_LVL_W-1:0] > LSC_LVL_MAX)) |=> $stable(supply_level_code))
		else $error("undefined level code accepted");

	AST_LVL_WRITE: assert property (@(posedge clock) disable iff (!arst_n) // R4
		(wr_lvl && (reg_wdata[LSC_LVL_W-1:0] <= LSC_LVL_MAX))
			|=> (supply_level_code == $past(reg_wdata[LSC_LVL_W-1:0])))
		else $error("level code not written");

	AST_GROUP_WRITE: assert property (@(posedge clock) disable iff (!arst_n) // R6
		(wr_grp && otp_done_q && (reg_wdata[LSC_GRP_LSB +: LSC_GRP_W] <= LSC_GRP_MAX))
			|=> (supply_delay_group == $past(reg_wdata[LSC_GRP_LSB +: LSC_GRP_W])))
		else $error("delay group not written");

	AST_CTL_WRITE: assert property (@(posedge clock) disable iff (!arst_n) // R9
		wr_ctl |=> (ctl_q == ($past(reg_wdata) & LSC_CTL_MASK)))
		else $error("control write kept reserved bits");

	// no disable here, the property is about the reset itself
	AST_CTL_RESET: assert property (@(posedge clock) // R7
		!arst_n |-> ((ctl_q == LSC_CTL_RESET) && !supply_enable))
		else $error("control not at reset value");

	// every read gets exactly one answer pulse, used for readback of reserved bits
	AST_READ_ANSWER: assert property (@(posedge clock) disable iff (!arst_n) // R9
		reg_rd |=> reg_rvalid)
		else $error("read not answered");

	AST_NO_SPURIOUS: assert property (@(posedge clock) disable iff (!arst_n) // R9
		!reg_rd |=> !reg_rvalid)
		else $error("read answer without a read");

endmodule

`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import lsc_pkg::*;
	// stimulus and observed signals
	logic       clock, arst_n, seq_request, reg_wr, reg_rd, reg_rvalid, ok;
	logic       supply_enable, always_on_enable;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rdat, v;
	logic [2:0] pm_state;
	logic [1:0] otp_rail_class, supply_rail_class;
	logic [3:0] otp_delay_group, supply_delay_group;
	logic [5:0] supply_level_code;
	int         fail_count, compares, cyc;

	lsc_regs u_dut (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.otp_rail_class(otp_rail_class), .otp_delay_group(otp_delay_group), .seq_request(seq_request),
		.pm_state(pm_state), .supply_enable(supply_enable), .supply_level_code(supply_level_code),
		.supply_rail_class(supply_rail_class), .supply_delay_group(supply_delay_group),
		.always_on_enable(always_on_enable));
	lsc_host_model u_host (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

	// free-running clock
	always #5 clock = ~clock;

	// compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// read with answer pulse check
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		u_host.rd(a, rdat, ok);
		chk({7'h00, ok}, 8'h01);
		chk(rdat, exp);
	endtask
	// enable paths need one edge after a change; settle waits for two
	task automatic settle();
		repeat (2) @(negedge clock);
	endtask
	task automatic give_verdict();
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// hang guard, well above the roughly 75 cycles needed
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			give_verdict();
		end
	end

	// main sequence
	initial begin
		clock = 1'b0;
		arst_n = 1'b0;
		seq_request = 1'b1;
		pm_state = LSC_PM_S0;
		otp_rail_class = LSC_CLASS_S;
		otp_delay_group = 4'h9;
		repeat (3) @(negedge clock);
		arst_n = 1'b1;
		@(negedge clock);
		rchk(LSC_CTL_ADDR, 8'h00);
		rchk(LSC_GRP_ADDR, 8'h29);
		rchk(LSC_LVL_ADDR, 8'h00);
		chk({7'h00, supply_enable}, 8'h00);
		chk({7'h00, always_on_enable}, 8'h00);
		seq_request = 1'b0;
		settle();
		chk({7'h00, supply_enable}, 8'h01);
		u_host.wr(LSC_CTL_ADDR, 8'hFD);
		rchk(LSC_CTL_ADDR, 8'h01);
		seq_request = 1'b1;
		settle();
		chk({7'h00, supply_enable}, 8'h00);
		u_host.wr(LSC_CTL_ADDR, 8'h02);
		seq_request = 1'b0;
		settle();
		chk({7'h00, supply_enable}, 8'h00);
		u_host.wr(LSC_CTL_ADDR, 8'h03);
		seq_request = 1'b1;
		settle();
		chk({7'h00, supply_enable}, 8'h01);
		// top legal level code, then one past it
		u_host.wr(LSC_LVL_ADDR, 8'h37);
		rchk(LSC_LVL_ADDR, 8'h37);
		chk({2'b00, supply_level_code}, 8'h37);
		u_host.wr(LSC_LVL_ADDR, 8'h38);
		rchk(LSC_LVL_ADDR, 8'h37);
		// every rail class, groups from 14 downwards
		for (int i = 0; i < 4; i++) begin
			v = 8'((i << 4) | (14 - i));
			u_host.wr(LSC_GRP_ADDR, v);
			rchk(LSC_GRP_ADDR, v);
			chk({6'h00, supply_rail_class}, 8'(i));
			chk({4'h0, supply_delay_group}, 8'(14 - i));
		end
		// undefined group 15 keeps group 11, class still updates
		u_host.wr(LSC_GRP_ADDR, 8'hCF);
		rchk(LSC_GRP_ADDR, 8'h0B);
		rchk(8'h00, 8'h00);
		// always-on supply across state changes
		pm_state = LSC_PM_S4;
		settle();
		chk({7'h00, always_on_enable}, 8'h01);
		pm_state = LSC_PM_S3;
		settle();
		chk({7'h00, always_on_enable}, 8'h01);
		pm_state = LSC_PM_G3;
		settle();
		chk({7'h00, always_on_enable}, 8'h00);
		pm_state = LSC_PM_S5;
		settle();
		chk({7'h00, always_on_enable}, 8'h00);
		// mid-run reset: control back to zero, sequencing reloads new otp defaults
		otp_rail_class = LSC_CLASS_U;
		otp_delay_group = 4'h3;
		arst_n = 1'b0;
		settle();
		arst_n = 1'b1;
		settle();
		rchk(LSC_CTL_ADDR, 8'h00);
		rchk(LSC_GRP_ADDR, 8'h13);
		rchk(LSC_LVL_ADDR, 8'h00);
		chk({7'h00, supply_enable}, 8'h00);
		chk({7'h00, always_on_enable}, 8'h00);
		give_verdict();
	end
endmodule

`default_nettype wire
